// ---- src/wdp_defines.svh ----
/*
  Constants of the watchdog with prescaler: register offsets, field
  positions, reset values and timing counts in base clock cycles.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef WDP_DEFINES_SVH
`define WDP_DEFINES_SVH

// Register port widths
`define WDP_ADDR_W 16
`define WDP_DATA_W 8

// Register offsets
`define WDP_CLEAR_ADDR 16'hFFFF
`define WDP_CFG_ADDR 16'h001F
`define WDP_PIN_ADDR 16'h001E
`define WDP_CAUSE_ADDR 16'h001D
`define WDP_COUNT_ADDR 16'h001C

// Field positions
`define WDP_CFG_DIS_BIT 0
`define WDP_CFG_STOP_BIT 1
`define WDP_CFG_SHORT_STOP_RECOVERY_SEL_BIT 2
`define WDP_CFG_PSEL_BIT 7
`define WDP_PIN_RESET_PIN_FUNCTION_ENABLE_BIT 0
`define WDP_CAUSE_WD_BIT 0

// Reset values
`define WDP_CFG_RESET 8'h00
`define WDP_PIN_RESET 8'h00

// Counter widths and low prescaler stages kept by a clear
`define WDP_PRE_W 12
`define WDP_CNT_W 6
`define WDP_KEEP_LO 4

// Timing in base clock cycles
`define WDP_LONG_PERIOD 262128
`define WDP_SHORT_PERIOD 8176
`define WDP_RST_PULSE 32
`define WDP_REC_SHORT 32
`define WDP_REC_LONG 4096
`define WDP_POR_DELAY 4096
`define WDP_TIMER_W 13

`endif

// ---- src/wdp_pkg.sv ----
/*
  Types of the watchdog with prescaler: mode enum, bus carrier and the
  packed state of the top module.
  Assumes wdp_defines.svh is on the include path.
*/
`include "wdp_defines.svh"

package wdp_pkg;

  // Stop mode sequencing
  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_stopped = 2'b01,
    mode_recover = 2'b10
  } wdp_mode_e;

  // Register port request
  typedef struct packed {
    logic [`WDP_ADDR_W-1:0] addr;
    logic [`WDP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wdp_bus_s;

  // Whole state of the top module
  typedef struct packed {
    wdp_mode_e mode;
    logic [`WDP_TIMER_W-1:0] rec_cnt;
    logic [`WDP_TIMER_W-1:0] por_cnt;
    logic por_done;
    logic por_fire;
    logic [`WDP_CNT_W-1:0] wcnt;
    logic [`WDP_CNT_W-1:0] hold_cnt;
    logic wd_reset;
    logic pin_drive;
    logic cause;
    logic [`WDP_DATA_W-1:0] cfg;
    logic cfg_written;
    logic [`WDP_DATA_W-1:0] pin_cfg;
    logic pin_written;
    logic [`WDP_DATA_W-1:0] rdata;
    logic stop_illegal;
    logic stop_taken;
    logic cpu_run;
    logic tv_meta;
    logic tv_sync;
  } wdp_state_s;

endpackage

// ---- src/wdp_prescaler.sv ----
/*
  Twelve-stage prescaler of the watchdog: counts base clock ticks and
  gives a carry out of its last stage.
  Assumes tick and clear inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "wdp_defines.svh"

module wdp_prescaler #(
  parameter int PRE_W = `WDP_PRE_W,
  parameter int KEEP_LO = `WDP_KEEP_LO
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Control
  input wire logic tick_in,
  input wire logic clear_all_in,
  input wire logic clear_upper_in,
  // Status
  output logic [PRE_W-1:0] count_out,
  output logic carry_out
);

  logic [PRE_W-1:0] count;
  logic [PRE_W-1:0] next_count;

  // Carry leaves the last stage on the tick that wraps the chain
  assign carry_out = tick_in & (&count);
  assign count_out = count;

  // Full clear wins over the upper clear; low stages survive the latter
  always_comb begin
    next_count = count;
    if (clear_all_in) begin
      next_count = '0; // RL7 RL8 RL9
    end else if (clear_upper_in) begin
      next_count = {{(PRE_W-KEEP_LO){1'b0}}, count[KEEP_LO-1:0]}; // RL4
    end else if (tick_in) begin
      next_count = count + 1'b1; // RL1
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ---- src/wdp_watchdog.sv ----
/*
  Watchdog with prescaler: a six-bit timeout counter behind a twelve-stage
  prescaler, a clear location, two write-once setup registers, stop mode entry
  and recovery timing, reset pin drive and the watchdog cause flag.
  Assumes the system clock is the base oscillator clock, that the register
  master follows a one-cycle strobe protocol with read data one cycle
  later, and that the rest of the chip turns the reset request into the
  device reset and reports other internal resets on internal_reset_in.
*/
`timescale 1ns/1ps
`include "wdp_defines.svh"

// How it works
// RL1: six-bit counter fed by twelve-stage prescaler
// RL2: timeout gives reset after selected period
// RL3: select 1 short 8176, 0 long 262128
// RL4: clear write zeroes counter, prescaler stages 12-5
// RL5: clear location reads reset vector low byte
// RL6: reset drives pin 32 cycles, sets flag
// RL7: stop instruction clears prescaler
// RL8: power-up clears prescaler 4096 cycles later
// RL9: internal reset clears prescaler and counter
// RL10: disable bit 1 stops, 0 runs watchdog
// RL11: never raises an interrupt, only reset
// RL12: monitor mode with test voltage disables
// RL13: keeps counting in wait; software clears it
// RL14: stop mode gates the base clock off
// RL15: break in monitor disables if bit set
// RL16: stop exit waits 32 or 4096 cycles
// RL17: low-voltage reset exit always waits long
// RL18: stop disabled means stop is illegal opcode
// RL19: software clears after reset and around stop
// RL20: counter advances on final carry when enabled
module wdp_watchdog #(
  parameter logic [`WDP_DATA_W-1:0] RESET_VEC_LO = 8'h00,
  parameter int POR_DELAY = `WDP_POR_DELAY,
  parameter int REC_LONG = `WDP_REC_LONG
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire wdp_pkg::wdp_bus_s bus_in,
  output logic [`WDP_DATA_W-1:0] rdata_out,
  // CPU and system events
  input wire logic stop_exec_in,
  input wire logic wait_mode_in,
  input wire logic wake_in,
  input wire logic lvi_reset_in,
  input wire logic internal_reset_in,
  // Monitor and break
  input wire logic monitor_mode_in,
  input wire logic test_voltage_level_in,
  input wire logic break_active_in,
  input wire logic break_watchdog_disable_in,
  // Reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  // Status towards the chip
  output logic wdog_reset_out,
  output logic stop_illegal_out,
  output logic stop_taken_out,
  output logic cpu_clock_run_out
);

  // Last counter value before timeout for a period in base cycles
  function automatic logic [`WDP_CNT_W-1:0] last_count(input int period);
    int carries;
    carries = (period + (1 << `WDP_KEEP_LO)) >> `WDP_PRE_W;
    last_count = `WDP_CNT_W'(carries - 1);
  endfunction

  // Register address match for a one-cycle strobe
  function automatic logic hit(input wdp_pkg::wdp_bus_s b,
                               input logic [`WDP_ADDR_W-1:0] a);
    hit = (b.addr == a);
  endfunction

  localparam logic [`WDP_CNT_W-1:0] LAST_LONG =
    last_count(`WDP_LONG_PERIOD);
  localparam logic [`WDP_CNT_W-1:0] LAST_SHORT =
    last_count(`WDP_SHORT_PERIOD);
  localparam logic [`WDP_TIMER_W-1:0] REC_SHORT_LOAD =
    `WDP_TIMER_W'(`WDP_REC_SHORT - 1);
  localparam logic [`WDP_TIMER_W-1:0] REC_LONG_LOAD =
    `WDP_TIMER_W'(REC_LONG - 1);
  localparam logic [`WDP_TIMER_W-1:0] POR_LAST =
    `WDP_TIMER_W'(POR_DELAY - 1);
  localparam logic [`WDP_CNT_W-1:0] HOLD_LAST =
    `WDP_CNT_W'(`WDP_RST_PULSE - 1);

  wdp_pkg::wdp_state_s st;
  wdp_pkg::wdp_state_s next_st;

  // Prescaler connections
  logic pre_tick;
  logic pre_clear_all;
  logic pre_clear_upper;
  logic pre_carry;
  logic [`WDP_PRE_W-1:0] pre_count;

  // Decoded strobes and enables
  logic clear_wr;
  logic cfg_wr;
  logic pin_wr;
  logic cause_rd;
  logic wd_enabled;
  logic wd_timeout;
  logic stop_ok;
  logic [`WDP_CNT_W-1:0] last_now;

  // Address decoding, one chain per strobe
  always_comb begin
    clear_wr = 1'b0;
    cfg_wr = 1'b0;
    pin_wr = 1'b0;
    cause_rd = 1'b0;
    if (bus_in.wr && hit(bus_in, `WDP_CLEAR_ADDR)) begin
      clear_wr = 1'b1; // RL4
    end else if (bus_in.wr && hit(bus_in, `WDP_CFG_ADDR)) begin
      cfg_wr = !st.cfg_written;
    end else if (bus_in.wr && hit(bus_in, `WDP_PIN_ADDR)) begin
      pin_wr = !st.pin_written;
    end
    if (bus_in.rd && hit(bus_in, `WDP_CAUSE_ADDR)) begin
      cause_rd = 1'b1;
    end
  end

  // Enable of the timeout path. Wait mode is not a term here on purpose:
  // the watchdog keeps running and software must keep clearing it.
  always_comb begin
    wd_enabled = 1'b1;
    if (st.cfg[`WDP_CFG_DIS_BIT]) begin
      wd_enabled = 1'b0; // RL10
    end else if (monitor_mode_in && st.tv_sync) begin
      wd_enabled = 1'b0; // RL12
    end else if (monitor_mode_in && break_active_in &&
                 break_watchdog_disable_in) begin
      wd_enabled = 1'b0; // RL15
    end else if (st.mode != wdp_pkg::mode_run) begin
      wd_enabled = 1'b0; // RL14
    end else if (st.wd_reset) begin
      wd_enabled = 1'b0;
    end
  end

  // Period select picks the terminal count
  assign last_now = st.cfg[`WDP_CFG_PSEL_BIT] ? LAST_SHORT
                                               : LAST_LONG; // RL3
  assign wd_timeout = wd_enabled && pre_carry &&
                      (st.wcnt == last_now) && !clear_wr; // RL2
  assign stop_ok = st.cfg[`WDP_CFG_STOP_BIT];

  // Base clock reaches the prescaler only in run mode, not while stopped or recovering
  assign pre_tick = (st.mode == wdp_pkg::mode_run); // RL14 RL13
  assign pre_clear_all = (stop_exec_in && stop_ok &&
                          st.mode == wdp_pkg::mode_run) // RL7
                         || st.por_fire // RL8
                         || internal_reset_in // RL9
                         || wd_timeout;
  assign pre_clear_upper = clear_wr; // RL4

  wdp_prescaler #(
    .PRE_W(`WDP_PRE_W),
    .KEEP_LO(`WDP_KEEP_LO)
  ) u_prescaler (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .tick_in(pre_tick),
    .clear_all_in(pre_clear_all),
    .clear_upper_in(pre_clear_upper),
    .count_out(pre_count),
    .carry_out(pre_carry)
  );

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.stop_illegal = 1'b0;
    next_st.stop_taken = 1'b0;
    next_st.por_fire = 1'b0;

    // Test voltage level arrives from a pin: two flops first
    next_st.tv_meta = test_voltage_level_in;
    next_st.tv_sync = st.tv_meta;

    // Power-up delay, then one clear of the prescaler
    if (!st.por_done) begin
      if (st.por_cnt == POR_LAST) begin
        next_st.por_done = 1'b1;
        next_st.por_fire = 1'b1; // RL8
      end else begin
        next_st.por_cnt = st.por_cnt + 1'b1;
      end
    end

    // Timeout counter; a clear in the same cycle beats the carry
    if (clear_wr || internal_reset_in) begin
      next_st.wcnt = '0; // RL4 RL9
    end else if (wd_timeout) begin
      next_st.wcnt = '0;
    end else if (wd_enabled && pre_carry) begin
      next_st.wcnt = st.wcnt + 1'b1; // RL20 RL1
    end

    // Reset request and reset pin hold, a reset and no interrupt
    if (wd_timeout) begin
      next_st.wd_reset = 1'b1; // RL2 RL11
      next_st.hold_cnt = '0;
      next_st.pin_drive = st.pin_cfg[`WDP_PIN_RESET_PIN_FUNCTION_ENABLE_BIT]; // RL6
      next_st.mode = wdp_pkg::mode_run;
      next_st.cpu_run = 1'b1;
    end else if (st.wd_reset) begin
      if (st.hold_cnt == HOLD_LAST) begin
        next_st.wd_reset = 1'b0; // RL6
        next_st.pin_drive = 1'b0;
      end else begin
        next_st.hold_cnt = st.hold_cnt + 1'b1;
      end
    end

    // Cause flag: a new timeout wins over a clearing read
    if (wd_timeout) begin
      next_st.cause = 1'b1; // RL6
    end else if (cause_rd) begin
      next_st.cause = 1'b0;
    end

    // Stop mode sequencing
    case (st.mode)
      wdp_pkg::mode_run: begin
        if (stop_exec_in && !wd_timeout && !st.wd_reset) begin
          if (stop_ok) begin
            next_st.mode = wdp_pkg::mode_stopped; // RL18
            next_st.stop_taken = 1'b1;
            next_st.cpu_run = 1'b0;
          end else begin
            next_st.stop_illegal = 1'b1; // RL18
          end
        end
      end
      wdp_pkg::mode_stopped: begin
        if (lvi_reset_in) begin
          next_st.mode = wdp_pkg::mode_recover;
          next_st.rec_cnt = REC_LONG_LOAD; // RL17
        end else if (wake_in) begin
          next_st.mode = wdp_pkg::mode_recover;
          next_st.rec_cnt = st.cfg[`WDP_CFG_SHORT_STOP_RECOVERY_SEL_BIT] ?
                            REC_SHORT_LOAD : REC_LONG_LOAD; // RL16
        end
      end
      wdp_pkg::mode_recover: begin
        if (lvi_reset_in) begin
          next_st.rec_cnt = REC_LONG_LOAD; // RL17
        end else if (st.rec_cnt == '0) begin
          next_st.mode = wdp_pkg::mode_run; // RL16
          next_st.cpu_run = 1'b1;
        end else begin
          next_st.rec_cnt = st.rec_cnt - 1'b1;
        end
      end
      default: begin
        next_st.mode = wdp_pkg::mode_run;
        next_st.cpu_run = 1'b1;
      end
    endcase

    // Write-once setup registers
    if (cfg_wr) begin
      next_st.cfg = bus_in.wdata; // RL10 RL3
      next_st.cfg_written = 1'b1;
    end
    if (pin_wr) begin
      next_st.pin_cfg = bus_in.wdata; // RL6
      next_st.pin_written = 1'b1;
    end

    // Read data stands one cycle after the strobe, zero otherwise
    next_st.rdata = '0;
    if (bus_in.rd) begin
      if (hit(bus_in, `WDP_CLEAR_ADDR)) begin
        next_st.rdata = RESET_VEC_LO; // RL5
      end else if (hit(bus_in, `WDP_CFG_ADDR)) begin
        next_st.rdata = st.cfg;
      end else if (hit(bus_in, `WDP_PIN_ADDR)) begin
        next_st.rdata = st.pin_cfg;
      end else if (hit(bus_in, `WDP_CAUSE_ADDR)) begin
        next_st.rdata = `WDP_DATA_W'(st.cause) << `WDP_CAUSE_WD_BIT;
      end else if (hit(bus_in, `WDP_COUNT_ADDR)) begin
        next_st.rdata = `WDP_DATA_W'(st.wcnt);
      end else begin
        next_st.rdata = '0;
      end
    end
  end

  // State register; setup values keep their documented reset values
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
      st.mode <= wdp_pkg::mode_run;
      st.cfg <= `WDP_CFG_RESET;
      st.pin_cfg <= `WDP_PIN_RESET;
      st.cpu_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register, except the constant low pin level
  assign rdata_out = st.rdata;
  assign wdog_reset_out = st.wd_reset;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_out = st.pin_drive; // RL6
  assign stop_illegal_out = st.stop_illegal;
  assign stop_taken_out = st.stop_taken;
  assign cpu_clock_run_out = st.cpu_run;

endmodule

// ---- dv/wdp_watchdog_monitor.sv ----
/*
  Port checker of the watchdog top: reset pulse, stop and read rules.
  Assumes a bind to wdp_watchdog, one clock and a synchronous reset.
*/
`timescale 1ns/1ps
`include "wdp_defines.svh"
module wdp_watchdog_monitor (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Requests seen
  input wire wdp_pkg::wdp_bus_s bus_in,
  input wire logic stop_exec_in,
  // Answers seen
  input wire logic [`WDP_DATA_W-1:0] rdata_out,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_out,
  input wire logic wdog_reset_out,
  input wire logic stop_illegal_out,
  input wire logic stop_taken_out,
  input wire logic cpu_clock_run_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [5:0] hi_cnt;
  // Cycles the reset request has stood so far; a counter avoids long repeats
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !wdog_reset_out) begin
      hi_cnt <= 6'h00;
    end else begin
      hi_cnt <= hi_cnt + 6'h01;
    end
  end
  // Port rules; the recovery check needs a long recovery of 32 or more
  AST_RST_LEN: assert property (
    $fell(wdog_reset_out) |-> hi_cnt == 6'h20)
    else $error("reset pulse not 32 cycles");
  AST_RST_MAX: assert property (
    wdog_reset_out |-> hi_cnt < 6'h20)
    else $error("reset pulse too long");
  AST_PIN_OE: assert property (
    reset_pin_oe_out |-> wdog_reset_out && !reset_pin_out)
    else $error("pin pulled low outside reset");
  AST_NO_RST_STOP: assert property (
    $rose(wdog_reset_out) |-> $past(cpu_clock_run_out))
    else $error("timeout while stopped");
  AST_STOP_TAKE: assert property (
    stop_taken_out |-> $past(stop_exec_in) && !cpu_clock_run_out)
    else $error("stop taken without request");
  AST_STOP_ILL: assert property (
    stop_illegal_out |-> $past(stop_exec_in) && cpu_clock_run_out &&
    !stop_taken_out)
    else $error("bad illegal stop pulse");
  AST_STOP_ONE: assert property (
    stop_taken_out |=> !stop_taken_out)
    else $error("stop pulse longer than one cycle");
  AST_RD_IDLE: assert property (
    !$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  AST_REC_MIN: assert property (
    $rose(cpu_clock_run_out) |-> !$past(cpu_clock_run_out, 32))
    else $error("recovery shorter than 32 cycles");
  // Main scenarios reached
  cover property ($rose(wdog_reset_out));
  cover property (stop_taken_out);
  cover property (stop_illegal_out);
  cover property ($rose(cpu_clock_run_out));
endmodule

// ---- dv/wdp_cpu_model.sv ----
/*
  CPU side model: one-cycle write and read strobes on the register port.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "wdp_defines.svh"
module wdp_cpu_model (
  // Clock
  input wire logic sys_clk_in,
  // Register port
  input wire logic [`WDP_DATA_W-1:0] rdata_in,
  output wdp_pkg::wdp_bus_s bus_out
);
  // Bus idles with both strobes low
  initial bus_out = '0;
  // Write any value; the block never stalls, so one edge takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    bus_out <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus_out <= '0;
  endtask
  // Read; the answer is taken at the edge closing the answer cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus_out <= '0;
    @(posedge sys_clk_in);
    v = rdata_in;
  endtask
endmodule

// ---- dv/wdp_watchdog_tb.sv ----
/*
  Self-checking bench of the watchdog top, one task per scenario.
  Assumes the CPU model on the register port and the port checker.
*/
`timescale 1ns/1ps
`include "wdp_defines.svh"
module wdp_watchdog_tb;
  localparam logic [15:0] CFG = `WDP_CFG_ADDR;
  localparam logic [15:0] PIN = `WDP_PIN_ADDR;
  localparam logic [15:0] CAU = `WDP_CAUSE_ADDR;
  localparam logic [15:0] CNT = `WDP_COUNT_ADDR;
  localparam logic [15:0] CLR = `WDP_CLEAR_ADDR;
  localparam int REC_L = 64; // Not below the short recovery of 32
  localparam logic [7:0] VEC = 8'h5A; // Arbitrary vector byte
  logic sys_clk_in, rstn_in, stop_exec_in, wait_mode_in, wake_in;
  logic lvi_reset_in, internal_reset_in, monitor_mode_in, tv, brk, bdis;
  logic reset_pin_out, reset_pin_oe_out, wdog_reset_out, prev;
  logic stop_illegal_out, stop_taken_out, cpu_clock_run_out;
  logic [7:0] rdata_out, d;
  wdp_pkg::wdp_bus_s bus;
  int n_fail, samples_checked, n_rst, k, n;

  wdp_cpu_model u_wdp_cpu_model (.sys_clk_in(sys_clk_in),
    .rdata_in(rdata_out), .bus_out(bus));
  // Short power-up and long recovery counts keep the run brief
  wdp_watchdog #(.RESET_VEC_LO(VEC), .POR_DELAY(16), .REC_LONG(REC_L))
  u_wdp_watchdog (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus_in(bus),
    .rdata_out(rdata_out), .stop_exec_in(stop_exec_in),
    .wait_mode_in(wait_mode_in), .wake_in(wake_in),
    .lvi_reset_in(lvi_reset_in), .internal_reset_in(internal_reset_in),
    .monitor_mode_in(monitor_mode_in), .test_voltage_level_in(tv),
    .break_active_in(brk), .break_watchdog_disable_in(bdis),
    .reset_pin_in(1'b1), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_out(reset_pin_oe_out), .wdog_reset_out(wdog_reset_out),
    .stop_illegal_out(stop_illegal_out), .stop_taken_out(stop_taken_out),
    .cpu_clock_run_out(cpu_clock_run_out));

  // Clock of 20 ns
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // Count reset requests so quiet spans can be judged
  always @(posedge sys_clk_in) begin
    if (wdog_reset_out && !prev) n_rst++;
    prev = wdog_reset_out;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    u_wdp_cpu_model.wr(a, v);
  endtask
  task automatic rd(input logic [15:0] a);
    u_wdp_cpu_model.rd(a, d);
  endtask
  // Reset, then wait out the power-up prescaler clear
  task automatic do_reset();
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
  endtask
  task automatic pulse_stop();
    @(posedge sys_clk_in);
    stop_exec_in <= 1'b1;
    @(posedge sys_clk_in);
    stop_exec_in <= 1'b0;
    #1;
  endtask
  // Edges until wdog_reset_out reads the given level (high or low), bounded
  task automatic wait_for(input logic want);
    n = 0;
    while (wdog_reset_out !== want && n < 9000) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
  endtask

  task automatic t_regs();
    do_reset();
    rd(CFG); chk(d, 8'h00);
    rd(CLR); chk(d, VEC);
    rd(16'h0010); chk(d, 8'h00);
    rd(CNT); chk(d, 8'h00);
    wr(CFG, 8'h81);
    wr(CFG, 8'h00);
    rd(CFG); chk(d, 8'h81);
    $display("regs done");
  endtask
  task automatic t_timeout();
    do_reset();
    wait_mode_in <= 1'b1;
    wr(CFG, 8'h80);
    wr(PIN, 8'h01);
    wr(CLR, 8'h00);
    wait_for(1'b1);
    chk(n >= 8176 && n <= 8193, 1);
    chk(reset_pin_oe_out, 1);
    wait_for(1'b0);
    chk(n, 32);
    rd(CAU); chk(d[0], 1);
    rd(CAU); chk(d[0], 0);
    wait_mode_in <= 1'b0;
    $display("timeout done");
  endtask
  task automatic t_clear();
    do_reset();
    wr(CFG, 8'h80);
    k = n_rst;
    repeat (3) begin
      repeat (5000) @(posedge sys_clk_in);
      rd(CNT); chk(d, 8'h01);
      wr(CLR, 8'hA5);
      rd(CNT); chk(d, 8'h00);
    end
    chk(n_rst, k);
    wr(CLR, 8'h00);
    repeat (6000) @(posedge sys_clk_in);
    internal_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    internal_reset_in <= 1'b0;
    rd(CNT); chk(d, 8'h00);
    repeat (4000) @(posedge sys_clk_in);
    rd(CNT); chk(d, 8'h00);
    $display("clear done");
  endtask
  task automatic t_disable();
    for (int m = 0; m < 3; m++) begin
      do_reset();
      monitor_mode_in <= (m > 0);
      tv <= (m == 1);
      brk <= (m == 2);
      bdis <= (m == 2);
      wr(CFG, (m == 0) ? 8'h81 : 8'h80);
      k = n_rst;
      repeat (9000) @(posedge sys_clk_in);
      chk(n_rst, k);
      {monitor_mode_in, tv, brk, bdis} <= 4'h0;
    end
    $display("disable done");
  endtask
  task automatic t_stop();
    for (int m = 0; m < 3; m++) begin
      do_reset();
      wr(CFG, (m == 1) ? 8'h82 : 8'h86);
      pulse_stop();
      chk(stop_taken_out, 1);
      chk(cpu_clock_run_out, 0);
      repeat (10) @(posedge sys_clk_in);
      wake_in <= 1'b1;
      lvi_reset_in <= (m == 2);
      @(posedge sys_clk_in);
      // A held low-voltage reset would keep reloading the recovery count
      wake_in <= 1'b0;
      lvi_reset_in <= 1'b0;
      n = 0;
      while (cpu_clock_run_out !== 1'b1 && n < 5000) begin
        @(posedge sys_clk_in);
        #1;
        n++;
      end
      chk(n, (m == 0) ? 32 : REC_L);
    end
    do_reset();
    wr(CFG, 8'h80);
    pulse_stop();
    chk(stop_illegal_out, 1);
    chk(cpu_clock_run_out, 1);
    $display("stop done");
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rstn_in, stop_exec_in, wait_mode_in, wake_in, lvi_reset_in} = 5'h00;
    {internal_reset_in, monitor_mode_in, tv, brk, bdis, prev} = 6'h00;
    {n_fail, samples_checked, n_rst} = 0;
    t_regs();
    t_timeout();
    t_clear();
    t_disable();
    t_stop();
    final_report();
  end
  // Watchdog of the bench: about 1.6 times the expected run
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end
endmodule

bind wdp_watchdog wdp_watchdog_monitor u_wdp_watchdog_monitor (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus_in(bus_in),
  .stop_exec_in(stop_exec_in), .rdata_out(rdata_out),
  .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out),
  .wdog_reset_out(wdog_reset_out), .stop_illegal_out(stop_illegal_out),
  .stop_taken_out(stop_taken_out), .cpu_clock_run_out(cpu_clock_run_out));
